/* File: sf_pkg.sv */
// Purpose: shared constants and types of the serial flash command front end
// Assumes: one 50 MHz system clock oversamples the serial link
// Notes  : opcodes, register fields, reset values and state encodings
package sf_pkg;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] NOP_CMD               = 8'h00;
  localparam logic [7:0] NORMAL_READ_CMD       = 8'h03;
  localparam logic [7:0] FAST_READ_CMD         = 8'h0B;
  localparam logic [7:0] DDR_READ_CMD          = 8'h0D;
  localparam logic [7:0] DUAL_OUT_READ_CMD     = 8'h3B;
  localparam logic [7:0] DUAL_LINE_READ_CMD    = 8'hBB;
  localparam logic [7:0] DDR_DUAL_READ_CMD     = 8'hBD;
  localparam logic [7:0] QUAD_OUT_READ_CMD     = 8'h6B;
  localparam logic [7:0] QUAD_LINE_READ_CMD    = 8'hEB;
  localparam logic [7:0] DDR_QUAD_READ_CMD     = 8'hED;
  localparam logic [7:0] PAGE_PROGRAM_CMD      = 8'h02;
  localparam logic [7:0] QUAD_PAGE_PROG_A_CMD  = 8'h32;
  localparam logic [7:0] QUAD_PAGE_PROG_B_CMD  = 8'h38;
  localparam logic [7:0] SECTOR_ERASE_A_CMD    = 8'hD7;
  localparam logic [7:0] SECTOR_ERASE_B_CMD    = 8'h20;
  localparam logic [7:0] BLOCK_ERASE_32K_CMD   = 8'h52;
  localparam logic [7:0] BLOCK_ERASE_64K_CMD   = 8'hD8;
  localparam logic [7:0] CHIP_ERASE_A_CMD      = 8'hC7;
  localparam logic [7:0] CHIP_ERASE_B_CMD      = 8'h60;
  localparam logic [7:0] WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD     = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0] BOOT_READ_CMD         = 8'h14;
  localparam logic [7:0] BOOT_WRITE_CMD        = 8'h15;
  localparam logic [7:0] FOUR_LINE_ENTER_CMD   = 8'h35;
  localparam logic [7:0] FOUR_LINE_EXIT_CMD    = 8'hF5;

  // ************************************************************
  // lines, dummy counts, fields
  // ************************************************************
  localparam logic [1:0]  W1               = 2'h0;
  localparam logic [1:0]  W2               = 2'h1;
  localparam logic [1:0]  W4               = 2'h2;
  localparam logic [3:0]  OE_W1            = 4'h2;
  localparam logic [3:0]  OE_W2            = 4'h3;
  localparam logic [3:0]  OE_W4            = 4'hF;
  localparam logic [4:0]  DUMMY_FAST       = 5'h08;
  localparam logic [4:0]  DUMMY_DUAL_IO    = 5'h04;
  localparam logic [4:0]  DUMMY_QUAD_IO    = 5'h06;
  localparam int          BOOT_ADDR_MSB    = 23;
  localparam int          BOOT_ADDR_LSB    = 5;
  localparam int          BOOT_DELAY_MSB   = 4;
  localparam int          BOOT_DELAY_LSB   = 1;
  localparam int          BOOT_EN_BIT      = 0;
  localparam logic [7:0]  BOOT_RSVD        = 8'h00;
  localparam logic [4:0]  BOOT_ALIGN       = 5'h00;
  localparam logic [23:0] BOOT_RESET       = 24'h000000;
  localparam int          SR_STATUS_WRITE_DISABLE          = 7;
  localparam int          SR_QE            = 6;
  localparam int          SR_BP_MSB        = 5;
  localparam int          SR_BP_LSB        = 2;
  localparam int          BLK_MSB          = 22;
  localparam int          BLK_LSB          = 16;
  localparam logic [7:0]  BLOCK_COUNT      = 8'h80;
  localparam logic [1:0]  ADDR_LAST        = 2'h2;
  localparam logic [1:0]  FIFO_DEPTH       = 2'h2;
  localparam logic [2:0]  STATUS_BYTES     = 3'h1;
  localparam logic [2:0]  BOOT_BYTES       = 3'h4;
  localparam logic [7:0]  FILL_BYTE        = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CMD   = 3'h1,
    ST_ADDR  = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DOUT  = 3'h6,
    ST_DIN   = 3'h7,
    ST_SKIP  = 3'h5,
    ST_BOOT  = 3'h4
  } state_t;

  typedef enum logic [1:0] {
    SRC_ARRAY  = 2'h0,
    SRC_STATUS = 2'h1,
    SRC_BOOT   = 2'h2
  } src_t;

  typedef enum logic [2:0] {
    AOP_NONE    = 3'h0,
    AOP_PROGRAM = 3'h1,
    AOP_SECTOR  = 3'h2,
    AOP_BLOCK32 = 3'h3,
    AOP_BLOCK64 = 3'h4,
    AOP_CHIP    = 3'h5
  } array_op_t;

endpackage

/* File: serial_flash_command_front_end.sv */
// Purpose: instruction front end of a serial flash, oversampling the link
// Assumes: link pins are asynchronous; array answers on the same clock
// Notes  : operations are committed when chip select rises
// Contract
// - boot start address bits 23:5, 32-byte aligned
// - boot delay field follows read dummy count
// - default boot delay: 8 cycles, 6 quad
// - bit 0 enables boot fetch, default off
// - bits 31:24 reserved, always zero
// - status write blocked when disable set, pin low
// - program, erase, status write need write latch
// - block protect bits fence array modifications
// - opcode captured in 8-bit instruction register
// - all fields shifted most significant bit first
// - single-edge: sample rising clock, chip selected
// - double-edge: sample both clock edges
// - opcode, then three address bytes, then data
// - D7h or 20h: sector erase, three-byte address
// - C7h or 60h: chip erase, no address
// - 32h or 38h: quad program, single-line mode
// - read dummy count includes mode byte
module serial_flash_command_front_end (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  input  wire logic        wp_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  input  wire logic        busy_i,
  input  wire logic        top_bottom_select_i,
  input  wire logic [3:0]  read_dummy_i,
  output logic             arr_read_o,
  output logic      [23:0] arr_addr_o,
  input  wire logic        arr_valid_i,
  input  wire logic [7:0]  arr_data_i,
  output logic             arr_ready_o,
  output logic             op_valid_o,
  output logic      [2:0]  op_kind_o,
  output logic      [23:0] op_addr_o,
  output logic             prog_valid_o,
  output logic      [7:0]  prog_data_o
);

  typedef struct packed {
    logic [2:0]          cs;
    logic [2:0]          sk;
    logic [1:0]          wp;
    logic [3:0]          io1;
    logic [3:0]          io2;
    sf_pkg::state_t      st;
    sf_pkg::state_t      after;
    logic [7:0]          instr;
    logic [2:0]          bits;
    logic [1:0]          nab;
    logic [23:0]         addr;
    logic [4:0]          cnt;
    logic [1:0]          win;
    logic [1:0]          wout;
    logic                ddr;
    sf_pkg::src_t        src;
    logic [31:0]         acc;
    logic [2:0]          nb;
    logic                ok;
    logic [7:0]          osh;
    logic [2:0]          ocnt;
    logic [1:0]          oidx;
    logic [3:0]          io_o;
    logic [3:0]          io_oe;
    logic                write_enable_latch;
    logic                status_write_disable;
    logic                qe;
    logic [3:0]          bp;
    logic [23:0]         abr;
    logic                four_line_instruction_mode;
    logic                rd;
    logic [1:0][7:0]     fd;
    logic [1:0]          fc;
    logic                fw;
    logic                fr;
    logic                opv;
    sf_pkg::array_op_t   opk;
    logic                pv;
    logic [7:0]          pd;
  } regs_t;

  regs_t               s_r;
  regs_t               s_nxt;
  logic                rise;
  logic                fall;
  logic                samp;
  logic                oedge;
  logic                cs_fall;
  logic                cs_rise;
  logic [2:0]          step;
  logic [2:0]          ostep;
  logic [31:0]         nacc;
  logic [2:0]          nbits;
  logic [1:0]          base;
  logic [4:0]          dfast;
  logic [4:0]          ddual;
  logic [4:0]          dquad;
  logic [4:0]          bdel;
  logic [7:0]          ob;
  logic [31:0]         boot_word;
  logic                push;
  logic                pop;
  sf_pkg::array_op_t   aop;
  logic                prot_hit;
  logic                din_ok;
  logic                commit;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] shin(input logic [31:0] a, input logic [1:0] w, input logic [3:0] l);
    case (w)
      sf_pkg::W2: shin = {a[29:0], l[1:0]};
      sf_pkg::W4: shin = {a[27:0], l};
      default:    shin = {a[30:0], l[0]};
    endcase
  endfunction

  function automatic logic [3:0] lines(input logic [7:0] b, input logic [1:0] w);
    case (w)
      sf_pkg::W2: lines = {2'h0, b[7:6]};
      sf_pkg::W4: lines = b[7:4];
      default:    lines = {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] oe_mask(input logic [1:0] w);
    case (w)
      sf_pkg::W2: oe_mask = sf_pkg::OE_W2;
      sf_pkg::W4: oe_mask = sf_pkg::OE_W4;
      default:    oe_mask = sf_pkg::OE_W1;
    endcase
  endfunction

  function automatic logic prot(input logic [3:0] bp, input logic tb, input logic [6:0] blk,
                                input logic chip);
    logic [7:0] span;
    span = 8'h01 << (bp[2:0] - 3'h1);
    if (bp == 4'h0)
      prot = 1'b0;
    else if (chip || bp[3])
      prot = 1'b1;
    else if (tb)
      prot = ({1'b0, blk} < span);
    else
      prot = ({1'b0, blk} >= (sf_pkg::BLOCK_COUNT - span));
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt   = s_r;
    s_nxt.cs  = {s_r.cs[1:0], cs_n_i};
    s_nxt.sk  = {s_r.sk[1:0], sck_i};
    s_nxt.wp  = {s_r.wp[0], wp_n_i};
    s_nxt.io1 = io_i;
    s_nxt.io2 = s_r.io1;
    s_nxt.opv = 1'b0;
    s_nxt.pv  = 1'b0;
    cs_fall = ~s_r.cs[1] & s_r.cs[2];
    cs_rise = s_r.cs[1] & ~s_r.cs[2];
    rise    = s_r.sk[1] & ~s_r.sk[2] & ~s_r.cs[1];
    fall    = ~s_r.sk[1] & s_r.sk[2] & ~s_r.cs[1];
    samp    = rise | (s_r.ddr & fall);
    oedge   = fall | (s_r.ddr & rise);
    step    = 3'h1 << s_r.win;
    ostep   = 3'h1 << s_r.wout;
    nacc    = shin(s_r.acc, s_r.win, s_r.io2);
    nbits   = s_r.bits + step;
    base    = s_r.four_line_instruction_mode ? sf_pkg::W4 : sf_pkg::W1;
    dfast   = (read_dummy_i != 4'h0) ? {1'b0, read_dummy_i} : sf_pkg::DUMMY_FAST;
    ddual   = (read_dummy_i != 4'h0) ? {1'b0, read_dummy_i} : sf_pkg::DUMMY_DUAL_IO;
    dquad   = (read_dummy_i != 4'h0) ? {1'b0, read_dummy_i} : sf_pkg::DUMMY_QUAD_IO;
    if (s_r.abr[sf_pkg::BOOT_DELAY_MSB:sf_pkg::BOOT_DELAY_LSB] != 4'h0)
      bdel = {1'b0, s_r.abr[sf_pkg::BOOT_DELAY_MSB:sf_pkg::BOOT_DELAY_LSB]};
    else
      bdel = s_r.qe ? dquad : dfast;
    boot_word = {sf_pkg::BOOT_RSVD, s_r.abr};
    ob        = s_r.osh;
    pop       = 1'b0;
    push      = arr_valid_i && (s_r.fc != sf_pkg::FIFO_DEPTH);
    case (s_r.instr)
      sf_pkg::PAGE_PROGRAM_CMD, sf_pkg::QUAD_PAGE_PROG_A_CMD,
      sf_pkg::QUAD_PAGE_PROG_B_CMD:                   aop = sf_pkg::AOP_PROGRAM;
      sf_pkg::SECTOR_ERASE_A_CMD,
      sf_pkg::SECTOR_ERASE_B_CMD:                     aop = sf_pkg::AOP_SECTOR;
      sf_pkg::BLOCK_ERASE_32K_CMD:                    aop = sf_pkg::AOP_BLOCK32;
      sf_pkg::BLOCK_ERASE_64K_CMD:                    aop = sf_pkg::AOP_BLOCK64;
      sf_pkg::CHIP_ERASE_A_CMD, sf_pkg::CHIP_ERASE_B_CMD: aop = sf_pkg::AOP_CHIP;
      default:                                        aop = sf_pkg::AOP_NONE;
    endcase
    prot_hit = prot(s_r.bp, top_bottom_select_i, s_r.addr[sf_pkg::BLK_MSB:sf_pkg::BLK_LSB],
                    aop == sf_pkg::AOP_CHIP);
    if (s_r.instr == sf_pkg::STATUS_WRITE_CMD)
      din_ok = (s_r.nb == sf_pkg::STATUS_BYTES);
    else if (s_r.instr == sf_pkg::BOOT_WRITE_CMD)
      din_ok = (s_r.nb == sf_pkg::BOOT_BYTES);
    else
      din_ok = (s_r.nb != 3'h0);
    din_ok = din_ok && (s_r.bits == 3'h0);
    commit = ((s_r.st == sf_pkg::ST_SKIP) && s_r.ok) || ((s_r.st == sf_pkg::ST_DIN) && din_ok);

    if (push) begin
      s_nxt.fd[s_r.fw] = arr_data_i;
      s_nxt.fw         = ~s_r.fw;
    end

    case (s_r.st)
      sf_pkg::ST_CMD: if (samp) begin
        s_nxt.acc  = nacc;
        s_nxt.bits = nbits;
        if (nbits == 3'h0) begin
          s_nxt.instr = nacc[7:0];
          s_nxt.acc   = 32'h0000_0000;
          s_nxt.st    = sf_pkg::ST_SKIP;
          s_nxt.after = sf_pkg::ST_DUMMY;
          s_nxt.wout  = base;
          s_nxt.src   = sf_pkg::SRC_ARRAY;
          s_nxt.cnt   = 5'h00;
          case (nacc[7:0])
            sf_pkg::NORMAL_READ_CMD: if (!s_r.four_line_instruction_mode) s_nxt.st = sf_pkg::ST_ADDR;
            sf_pkg::FAST_READ_CMD, sf_pkg::DDR_READ_CMD: begin
              s_nxt.st  = sf_pkg::ST_ADDR;
              s_nxt.cnt = dfast;
              s_nxt.ddr = (nacc[7:0] == sf_pkg::DDR_READ_CMD);
            end
            sf_pkg::DUAL_OUT_READ_CMD, sf_pkg::QUAD_OUT_READ_CMD: if (!s_r.four_line_instruction_mode) begin
              s_nxt.st   = sf_pkg::ST_ADDR;
              s_nxt.cnt  = dfast;
              s_nxt.wout = (nacc[7:0] == sf_pkg::DUAL_OUT_READ_CMD) ? sf_pkg::W2 : sf_pkg::W4;
            end
            sf_pkg::DUAL_LINE_READ_CMD, sf_pkg::DDR_DUAL_READ_CMD: if (!s_r.four_line_instruction_mode) begin
              s_nxt.st   = sf_pkg::ST_ADDR;
              s_nxt.cnt  = ddual;
              s_nxt.win  = sf_pkg::W2;
              s_nxt.wout = sf_pkg::W2;
              s_nxt.ddr  = (nacc[7:0] == sf_pkg::DDR_DUAL_READ_CMD);
            end
            sf_pkg::QUAD_LINE_READ_CMD, sf_pkg::DDR_QUAD_READ_CMD: begin
              s_nxt.st   = sf_pkg::ST_ADDR;
              s_nxt.cnt  = dquad;
              s_nxt.win  = sf_pkg::W4;
              s_nxt.wout = sf_pkg::W4;
              s_nxt.ddr  = (nacc[7:0] == sf_pkg::DDR_QUAD_READ_CMD);
            end
            sf_pkg::PAGE_PROGRAM_CMD: begin
              s_nxt.st    = sf_pkg::ST_ADDR;
              s_nxt.after = sf_pkg::ST_DIN;
            end
            sf_pkg::QUAD_PAGE_PROG_A_CMD, sf_pkg::QUAD_PAGE_PROG_B_CMD: if (!s_r.four_line_instruction_mode) begin
              s_nxt.st    = sf_pkg::ST_ADDR;
              s_nxt.after = sf_pkg::ST_DIN;
              s_nxt.wout  = sf_pkg::W4;
            end
            sf_pkg::SECTOR_ERASE_A_CMD, sf_pkg::SECTOR_ERASE_B_CMD,
            sf_pkg::BLOCK_ERASE_32K_CMD, sf_pkg::BLOCK_ERASE_64K_CMD: begin
              s_nxt.st    = sf_pkg::ST_ADDR;
              s_nxt.after = sf_pkg::ST_SKIP;
            end
            sf_pkg::CHIP_ERASE_A_CMD, sf_pkg::CHIP_ERASE_B_CMD,
            sf_pkg::WRITE_ENABLE_CMD, sf_pkg::WRITE_DISABLE_CMD: s_nxt.ok = 1'b1;
            sf_pkg::FOUR_LINE_ENTER_CMD: s_nxt.ok = ~s_r.four_line_instruction_mode;
            sf_pkg::FOUR_LINE_EXIT_CMD:  s_nxt.ok = s_r.four_line_instruction_mode;
            sf_pkg::STATUS_READ_CMD: begin
              s_nxt.st  = sf_pkg::ST_DOUT;
              s_nxt.src = sf_pkg::SRC_STATUS;
            end
            sf_pkg::BOOT_READ_CMD: begin
              s_nxt.st  = sf_pkg::ST_DOUT;
              s_nxt.src = sf_pkg::SRC_BOOT;
            end
            sf_pkg::STATUS_WRITE_CMD, sf_pkg::BOOT_WRITE_CMD: s_nxt.st = sf_pkg::ST_DIN;
            default: ;
          endcase
        end
      end
      sf_pkg::ST_ADDR: if (samp) begin
        s_nxt.acc  = nacc;
        s_nxt.bits = nbits;
        if (nbits == 3'h0) begin
          s_nxt.nab = s_r.nab + 2'h1;
          if (s_r.nab == sf_pkg::ADDR_LAST) begin
            s_nxt.addr = nacc[23:0];
            s_nxt.acc  = 32'h0000_0000;
            s_nxt.nab  = 2'h0;
            s_nxt.st   = s_r.after;
            case (s_r.after)
              sf_pkg::ST_DUMMY: begin
                s_nxt.rd = 1'b1;
                if (s_r.cnt == 5'h00)
                  s_nxt.st = sf_pkg::ST_DOUT;
              end
              sf_pkg::ST_DIN: s_nxt.win = s_r.wout;
              default:        s_nxt.ok  = 1'b1;
            endcase
          end
        end
      end
      sf_pkg::ST_DUMMY, sf_pkg::ST_BOOT: if (rise) begin
        s_nxt.cnt = s_r.cnt - 5'h01;
        if (s_r.cnt <= 5'h01)
          s_nxt.st = sf_pkg::ST_DOUT;
      end
      sf_pkg::ST_DOUT: if (oedge) begin
        if (s_r.ocnt == 3'h0) begin
          s_nxt.oidx = s_r.oidx + 2'h1;
          case (s_r.src)
            sf_pkg::SRC_STATUS: ob = {s_r.status_write_disable, s_r.qe, s_r.bp, s_r.write_enable_latch, busy_i};
            sf_pkg::SRC_BOOT:   ob = boot_word[{~s_r.oidx, 3'h0} +: 8];
            default: begin
              pop = (s_r.fc != 2'h0);
              ob  = pop ? s_r.fd[s_r.fr] : sf_pkg::FILL_BYTE;
            end
          endcase
        end
        s_nxt.io_o  = lines(ob, s_r.wout);
        s_nxt.io_oe = oe_mask(s_r.wout);
        s_nxt.osh   = ob << ostep;
        s_nxt.ocnt  = s_r.ocnt + ostep;
      end
      sf_pkg::ST_DIN: if (samp) begin
        s_nxt.acc  = nacc;
        s_nxt.bits = nbits;
        if (nbits == 3'h0) begin
          if (s_r.nb != 3'h7)
            s_nxt.nb = s_r.nb + 3'h1;
          s_nxt.pv = (aop == sf_pkg::AOP_PROGRAM) && s_r.write_enable_latch && !prot_hit;
          s_nxt.pd = nacc[7:0];
        end
      end
      sf_pkg::ST_SKIP: if (samp) s_nxt.ok = 1'b0;
      default: ;
    endcase

    if (pop)
      s_nxt.fr = ~s_r.fr;
    s_nxt.fc = s_r.fc + {1'b0, push} - {1'b0, pop};

    if (cs_fall) begin
      s_nxt.st    = sf_pkg::ST_CMD;
      s_nxt.instr = sf_pkg::NOP_CMD;
      s_nxt.bits  = 3'h0;
      s_nxt.acc   = 32'h0000_0000;
      s_nxt.nab   = 2'h0;
      s_nxt.nb    = 3'h0;
      s_nxt.ok    = 1'b0;
      s_nxt.win   = base;
      s_nxt.ddr   = 1'b0;
      s_nxt.ocnt  = 3'h0;
      s_nxt.oidx  = 2'h0;
      if (s_r.abr[sf_pkg::BOOT_EN_BIT]) begin
        s_nxt.st   = sf_pkg::ST_BOOT;
        s_nxt.cnt  = bdel;
        s_nxt.src  = sf_pkg::SRC_ARRAY;
        s_nxt.wout = s_r.qe ? sf_pkg::W4 : sf_pkg::W1;
        s_nxt.addr = {s_r.abr[sf_pkg::BOOT_ADDR_MSB:sf_pkg::BOOT_ADDR_LSB], sf_pkg::BOOT_ALIGN};
        s_nxt.rd   = 1'b1;
      end
    end

    if (cs_rise) begin
      s_nxt.st    = sf_pkg::ST_IDLE;
      s_nxt.io_oe = 4'h0;
      s_nxt.rd    = 1'b0;
      s_nxt.ddr   = 1'b0;
      s_nxt.fc    = 2'h0;
      s_nxt.fw    = 1'b0;
      s_nxt.fr    = 1'b0;
      if (commit) begin
        case (s_r.instr)
          sf_pkg::WRITE_ENABLE_CMD:    s_nxt.write_enable_latch = 1'b1;
          sf_pkg::WRITE_DISABLE_CMD:   s_nxt.write_enable_latch = 1'b0;
          sf_pkg::FOUR_LINE_ENTER_CMD: s_nxt.four_line_instruction_mode = 1'b1;
          sf_pkg::FOUR_LINE_EXIT_CMD:  s_nxt.four_line_instruction_mode = 1'b0;
          sf_pkg::STATUS_WRITE_CMD: if (s_r.write_enable_latch) begin
            s_nxt.write_enable_latch = 1'b0;
            if (!(s_r.status_write_disable && !s_r.wp[1])) begin
              s_nxt.status_write_disable = s_r.acc[sf_pkg::SR_STATUS_WRITE_DISABLE];
              s_nxt.qe   = s_r.acc[sf_pkg::SR_QE];
              s_nxt.bp   = s_r.acc[sf_pkg::SR_BP_MSB:sf_pkg::SR_BP_LSB];
            end
          end
          sf_pkg::BOOT_WRITE_CMD: if (s_r.write_enable_latch) begin
            s_nxt.write_enable_latch = 1'b0;
            s_nxt.abr = s_r.acc[sf_pkg::BOOT_ADDR_MSB:sf_pkg::BOOT_EN_BIT];
          end
          default: if (s_r.write_enable_latch && aop != sf_pkg::AOP_NONE) begin
            s_nxt.write_enable_latch = 1'b0;
            if (!prot_hit) begin
              s_nxt.opv = 1'b1;
              s_nxt.opk = aop;
            end
          end
        endcase
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r     <= '0;
      s_r.cs  <= 3'h7;
      s_r.wp  <= 2'h3;
      s_r.abr <= sf_pkg::BOOT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign io_o         = s_r.io_o;
  assign io_oe_o      = s_r.io_oe;
  assign arr_read_o   = s_r.rd;
  assign arr_addr_o   = s_r.addr;
  assign arr_ready_o  = (s_r.fc != sf_pkg::FIFO_DEPTH);
  assign op_valid_o   = s_r.opv;
  assign op_kind_o    = s_r.opk;
  assign op_addr_o    = s_r.addr;
  assign prog_valid_o = s_r.pv;
  assign prog_data_o  = s_r.pd;

endmodule

/* File: sf_front_end_monitor.sv */
// Purpose: port checks of the flash front end
// Assumes: one clock domain, synchronous active-low reset
// Notes  : idle_r counts deselected cycles, saturating at 7
module sf_front_end_monitor (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic       arr_read_o,
  input wire logic       arr_ready_o,
  input wire logic       op_valid_o,
  input wire logic [2:0] op_kind_o,
  input wire logic       prog_valid_o
);
  logic [2:0] idle_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clk_i) begin
    idle_r <= (!rst_n_i || !cs_n_i) ? 3'h0 : idle_r + {2'h0, idle_r != 3'h7};
  end
  // ****
  // properties
  // ****
  property p_idle; idle_r == 3'h7 |-> io_oe_o == 4'h0 && !arr_read_o && arr_ready_o; endproperty
  a_idle: assert property (p_idle) else $error("outputs active while deselected");
  property p_oe; io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
  a_oe: assert property (p_oe) else $error("bad output enable set");
  property p_kind; op_valid_o |-> op_kind_o inside {[3'h1:3'h5]}; endproperty
  a_kind: assert property (p_kind) else $error("bad operation kind");
  property p_pulse; op_valid_o |=> !op_valid_o [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("operation committed twice");
  property p_close; op_valid_o |-> $past(cs_n_i, 2) && cs_n_i; endproperty
  a_close: assert property (p_close) else $error("operation inside a frame");
  property p_prog; prog_valid_o |-> (!op_valid_o && io_oe_o == 4'h0) ##1 !prog_valid_o [*2]; endproperty
  a_prog: assert property (p_prog) else $error("program byte pulse malformed");
  property p_start; $rose(arr_read_o) |-> $past(cs_n_i, 2) == 1'b0 && !cs_n_i; endproperty
  a_start: assert property (p_start) else $error("array read outside a frame");
  property p_flush; $rose(cs_n_i) |-> ##[3:8] (!arr_read_o && arr_ready_o); endproperty
  a_flush: assert property (p_flush) else $error("read stream not flushed");
  c_chip: cover property (op_valid_o && op_kind_o == 3'h5);
  c_prog: cover property (prog_valid_o);
  c_full: cover property (arr_read_o && !arr_ready_o);
endmodule

/* File: sf_host_model.sv */
// Purpose: host controller model driving the serial link
// Assumes: half link period is four system clocks
// Notes  : released lines show the inverse of their last value
module sf_host_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] dev_io_i,
  output logic            cs_n_o,
  output logic            sck_o,
  output logic      [3:0] io_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'hA;
  end
  task automatic half();
    repeat (4) @(posedge clk_i);
    #2;
  endtask
  // ****
  // frame tasks
  // ****
  task automatic open_frame();
    cs_n_o = 1'b0;
    half();
  endtask
  // reply bit sampled just before the falling edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      io_o[0] = tx[i];
      half();
      sck_o = 1'b1;
      half();
      rx[i] = dev_io_i[1];
      sck_o = 1'b0;
    end
  endtask
  task automatic close_frame();
    half();
    cs_n_o = 1'b1;
    io_o = ~io_o;
    repeat (10) half();
  endtask
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench of the flash front end
// Assumes: host model drives the link, bench plays the array
// Notes  : array byte at address a is mem(a)
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wp_n_i = 1'b1, busy_i = 1'b1;
  logic        arr_valid_i = 1'b0, acc = 1'b0, rd_q = 1'b0, cs_n, sck;
  logic        arr_read_o, arr_ready_o, op_valid_o, prog_valid_o;
  logic [7:0]  arr_data_i = 8'h00, prog_data_o, last_prog, rx [$], q [$];
  logic [7:0]  code [7] = '{8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02};
  logic [2:0]  kind [7] = '{3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h1};
  logic [2:0]  op_kind_o, last_kind, kd;
  logic [3:0]  hio, io_o, io_oe_o, line;
  logic [23:0] ptr = 24'h0, a, arr_addr_o, op_addr_o, last_addr;
  logic [31:0] bv;
  int          seed = 27, fail_count = 0, checks_done = 0, n_ops = 0, n_prog = 0;
  assign line = (io_oe_o & io_o) | (~io_oe_o & hio);
  always #10 clk_i = ~clk_i;
  serial_flash_command_front_end i_dut (.clk_i, .rst_n_i, .cs_n_i(cs_n), .sck_i(sck), .wp_n_i, .io_i(line),
    .io_o, .io_oe_o, .busy_i, .top_bottom_select_i(1'b0), .read_dummy_i(4'h0), .arr_read_o, .arr_addr_o,
    .arr_valid_i, .arr_data_i, .arr_ready_o, .op_valid_o, .op_kind_o, .op_addr_o, .prog_valid_o, .prog_data_o);
  sf_host_model h (.clk_i, .dev_io_i(line), .cs_n_o(cs_n), .sck_o(sck), .io_o(hio));
  function automatic logic [7:0] mem(input logic [23:0] ad);
    return ad[7:0] ^ 8'h5A;
  endfunction
  // ****
  // array side and observers
  // ****
  always @(negedge clk_i) begin
    acc = arr_valid_i && arr_ready_o;
    if (op_valid_o === 1'b1) {n_ops, last_kind, last_addr} = {n_ops + 1, op_kind_o, op_addr_o};
    if (prog_valid_o === 1'b1) {n_prog, last_prog} = {n_prog + 1, prog_data_o};
  end
  always @(posedge clk_i) begin
    #2;
    if (acc) ptr = ptr + 24'h1;
    if (!rd_q) ptr = arr_addr_o;
    arr_valid_i = arr_read_o && (!rd_q || $random(seed) % 3 != 0);
    rd_q = arr_read_o;
    arr_data_i = mem(ptr);
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [7:0] b [$]);
    logic [7:0] r;
    rx = {};
    h.open_frame();
    foreach (b[i]) begin
      h.xfer(b[i], r);
      rx.push_back(r);
    end
    h.close_frame();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    h.half();
    frame({8'h05, 8'h00});
    check("status", 24'h01, rx[1]);
    busy_i = 1'b0;
    frame({8'h06});
    frame({8'h05, 8'h00});
    check("latch set", 24'h02, rx[1]);
    frame({8'h04});
    frame({8'h05, 8'h00});
    check("latch clear", 24'h00, rx[1]);
    for (int k = 0; k < 14; k++) begin
      a = 24'($random(seed));
      kd = kind[k % 7];
      q = {code[k % 7]};
      if (kd != 3'h5) q = {q, a[23:16], a[15:8], a[7:0]};
      if (kd == 3'h1) q.push_back(a[15:8]);
      if (k > 6) frame({8'h06});
      {n_ops, n_prog} = 0;
      frame(q);
      check("op count", 24'(k > 6), 24'(n_ops));
      check("prog count", 24'(k > 6 && kd == 3'h1), 24'(n_prog));
      if (k > 6) check("op kind", kd, last_kind);
      if (k > 6 && kd != 3'h5) check("op addr", a, last_addr);
      if (k > 6 && kd == 3'h1) check("prog data", a[15:8], last_prog);
    end
    frame({8'h03, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 3; i++) check("read byte", mem(a + 24'(i)), rx[4 + i]);
    frame({8'h06});
    frame({8'h01, 8'h80});
    frame({8'h05, 8'h00});
    check("status wd", 24'h80, rx[1] & 8'hFD);
    wp_n_i = 1'b0;
    frame({8'h06});
    frame({8'h01, 8'h3C});
    frame({8'h05, 8'h00});
    check("status locked", 24'h80, rx[1]);
    wp_n_i = 1'b1;
    frame({8'h06});
    frame({8'h01, 8'h3C});
    frame({8'h06});
    n_ops = 0;
    frame({8'h20, a[23:16], a[15:8], a[7:0]});
    check("protected erase", 24'h0, 24'(n_ops));
    for (int j = 0; j < 2; j++) begin
      bv = $random(seed);
      bv[4:0] = j ? 5'h01 : 5'h1E;
      frame({8'h06});
      frame({8'h15, bv[31:24], bv[23:16], bv[15:8], bv[7:0]});
      if (j == 0) frame({8'h14, 8'h00, 8'h00, 8'h00, 8'h00});
      if (j == 0) check("boot top", 24'h0, rx[1]);
      if (j == 0) check("boot low", bv[23:0], {rx[2], rx[3], rx[4]});
    end
    frame({8'h00, 8'h00});
    check("boot data", mem({bv[23:5], 5'h00}), rx[1]);
    rst_n_i = 1'b0;
    repeat (2) h.half();
    rst_n_i = 1'b1;
    h.half();
    frame({8'h05, 8'h00});
    check("status after reset", 24'h00, rx[1]);
    tally_and_finish();
  end
endmodule
bind serial_flash_command_front_end sf_front_end_monitor i_mon (.clk_i, .rst_n_i, .cs_n_i, .io_oe_o,
  .arr_read_o, .arr_ready_o, .op_valid_o, .op_kind_o, .prog_valid_o);
